/* rtl/esci_top.sv */
// external stop control inputs: halt, failure clear, skip and resume handling
// Behaviour
// - halt open keeps robot stopped, motor off
// - halt open blocks operation, reports error 2008
// - halt open drops motor in every mode
// - halt open while running: decelerate, off, internal
// - halt open while halted: off, resume later
// - motion halt beats every other input
// - step halt edge stops after current step
// - step halt open at start: single step
// - pendant accepted only after halt edge
// - instant halt edge stops mid step
// - prep start with failure clear clears failure
// - failure clear masks prep start requests
// - skip in enabled region abandons step
// - skip makes start look momentarily open
// - resume input resumes halted program
// - resume input honoured in external mode only
// - resume not permitted raises error 27a8
// - start acts only on rising edge
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
module esci_top #(
    parameter int HALT_MIN_CYC = esci_pkg::IHALT_MIN_MS * esci_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RSTN,
    // discrete inputs, high means shorted
    input  wire logic [esci_pkg::N_IN-1:0]  IN_SHORTED,
    // wishbone slave
    input  wire logic                       WB_CYC_I,
    input  wire logic                       WB_STB_I,
    input  wire logic                       WB_WE_I,
    input  wire logic [3:0]                 WB_ADR_I,
    input  wire logic [3:0]                 WB_SEL_I,
    input  wire logic [31:0]                WB_DAT_I,
    output logic      [31:0]                WB_DAT_O,
    output logic                            WB_ACK_O,
    // status to the sequencer and the drive
    output esci_pkg::esci_stat_t            STATUS
);
    localparam int CW = $clog2(HALT_MIN_CYC + 1);

    typedef struct packed {
        esci_pkg::esci_in_t   prev;
        esci_pkg::esci_run_t  run;
        logic [31:0]          ctrl;
        logic [15:0]          err;
        logic                 single_step;
        logic                 halted_prog;
        logic [CW-1:0]        ih_cnt;
        logic                 ih_armed;
        logic [31:0]          dat;
        logic                 ack;
        esci_pkg::esci_stat_t stat;
    } esci_top_t;

    esci_top_t         st_r;
    esci_top_t         st_nxt;
    esci_pkg::esci_in_t in_s;
    logic [esci_pkg::N_IN-1:0] lvl;

    // pins pass four flops before any edge detection
    esci_sync #(
        .N (esci_pkg::N_IN)
    ) u_sync (
        .clk   (CLK),
        .rstn  (RSTN),
        .raw   (IN_SHORTED),
        .level (lvl)
    );
    assign in_s = esci_pkg::esci_in_t'(lvl);

    // edge events and next-state logic
    always_comb begin
        logic start_rise;
        logic step_fall;
        logic inst_fall;
        logic prep_rise;
        logic wr;
        logic rd_valid;
        logic err_new;
        start_rise = 1'b0;
        step_fall  = 1'b0;
        inst_fall  = 1'b0;
        prep_rise  = 1'b0;
        wr         = 1'b0;
        rd_valid   = 1'b0;
        err_new    = 1'b0;
        st_nxt     = st_r;
        st_nxt.prev = in_s;
        st_nxt.stat.skip_step   = 1'b0;
        st_nxt.stat.restart_top = 1'b0;
        st_nxt.stat.resume      = 1'b0;

        // skip forces start low so a held start yields a fresh edge later
        start_rise = in_s.prog_start && !st_r.prev.prog_start && !in_s.motion_skip;
        if (in_s.motion_skip) begin
            st_nxt.prev.prog_start = 1'b0;
        end
        step_fall = !in_s.step_halt && st_r.prev.step_halt;
        prep_rise = in_s.prep_start && !st_r.prev.prep_start;

        // instant halt counts only once held open long enough
        if (in_s.instant_halt) begin
            st_nxt.ih_cnt   = '0;
            st_nxt.ih_armed = st_r.prev.instant_halt || st_r.ih_armed;
        end else if (st_r.ih_cnt != CW'(HALT_MIN_CYC)) begin
            st_nxt.ih_cnt = st_r.ih_cnt + CW'(1);
        end
        inst_fall = !in_s.instant_halt && st_r.ih_armed
                    && st_r.ih_cnt == CW'(HALT_MIN_CYC - 1);

        if (!in_s.motion_halt) begin
            // highest priority: nothing else is looked at
            st_nxt.stat.motor_on = 1'b0;
            st_nxt.stat.blocked  = 1'b1;
            st_nxt.err           = esci_pkg::ERR_HALT_OPEN;
            if (st_r.run == esci_pkg::ST_RUN) begin
                st_nxt.run = esci_pkg::ST_DECEL;
                st_nxt.stat.motor_on = st_r.stat.motor_on;
            end else if (st_r.run == esci_pkg::ST_DECEL) begin
                st_nxt.stat.motor_on = st_r.stat.motor_on && !st_r.ctrl[esci_pkg::CTRL_DECEL_DONE];
                if (st_r.ctrl[esci_pkg::CTRL_DECEL_DONE]) begin
                    st_nxt.run = esci_pkg::ST_INSTH;
                    st_nxt.stat.ext_mode = 1'b0;
                    st_nxt.stat.in_operation = 1'b0;
                    st_nxt.halted_prog = 1'b1;
                end
            end else if (st_r.run != esci_pkg::ST_IDLE) begin
                st_nxt.halted_prog = 1'b1;
            end
        end else begin
            st_nxt.stat.blocked = 1'b0;
            if (st_r.err == esci_pkg::ERR_HALT_OPEN) begin
                st_nxt.err = esci_pkg::ERR_NONE;
            end
            if (st_r.run == esci_pkg::ST_DECEL) begin
                st_nxt.run = esci_pkg::ST_INSTH;
                st_nxt.stat.in_operation = 1'b0;
                st_nxt.halted_prog = 1'b1;
            end
            // failure recovery and preparation
            if (st_r.ctrl[esci_pkg::CTRL_FAIL_SET]) begin
                st_nxt.stat.failure = 1'b1;
                st_nxt.stat.motor_on = 1'b0;
            end else if (prep_rise && in_s.failure_clear) begin
                st_nxt.stat.failure = 1'b0;
            end
            if (prep_rise && !in_s.failure_clear && in_s.prep_bits && !st_r.stat.failure) begin
                st_nxt.stat.motor_on = 1'b1;
                st_nxt.stat.ext_mode = 1'b1;
            end
            // halt edges set pendant permission
            if (step_fall || inst_fall) begin
                st_nxt.stat.pendant_ok = 1'b1;
            end else if (start_rise) begin
                st_nxt.stat.pendant_ok = 1'b0;
            end
            case (st_r.run)
                esci_pkg::ST_IDLE, esci_pkg::ST_STEPH, esci_pkg::ST_INSTH: begin
                    if (start_rise && st_r.stat.motor_on && !st_r.stat.failure) begin
                        if (in_s.resume_halted && st_r.stat.ext_mode) begin
                            if (st_r.ctrl[esci_pkg::CTRL_CONT_PERMIT]) begin
                                st_nxt.run = esci_pkg::ST_RUN;
                                st_nxt.stat.resume = st_r.halted_prog;
                            end else begin
                                st_nxt.err = esci_pkg::ERR_NO_CONTINUE;
                                err_new    = 1'b1;
                            end
                        end else begin
                            st_nxt.run = esci_pkg::ST_RUN;
                            st_nxt.stat.resume = st_r.halted_prog;
                        end
                        st_nxt.single_step = !in_s.step_halt;
                    end
                    if (st_nxt.run == esci_pkg::ST_RUN) begin
                        st_nxt.stat.in_operation = 1'b1;
                        st_nxt.halted_prog = 1'b0;
                    end
                end
                esci_pkg::ST_RUN: begin
                    if (inst_fall) begin
                        st_nxt.run = esci_pkg::ST_INSTH;
                        st_nxt.stat.in_operation = 1'b0;
                        st_nxt.halted_prog = 1'b1;
                    end else if ((step_fall || st_r.single_step)
                                 && st_r.ctrl[esci_pkg::CTRL_STEP_DONE]) begin
                        st_nxt.run = esci_pkg::ST_STEPH;
                        st_nxt.stat.in_operation = 1'b0;
                        st_nxt.halted_prog = 1'b1;
                    end else if (step_fall) begin
                        st_nxt.single_step = 1'b1;
                    end
                    if (in_s.motion_skip && !st_r.prev.motion_skip
                        && st_r.ctrl[esci_pkg::CTRL_SKIP_REGION]
                        && st_r.ctrl[esci_pkg::CTRL_MOTION_CMD]) begin
                        st_nxt.stat.skip_step = 1'b1;
                    end
                end
                // halt shorted again mid deceleration: keep the program halted, not idle
                esci_pkg::ST_DECEL: begin
                    st_nxt.run = esci_pkg::ST_INSTH;
                end
                default: begin
                    st_nxt.run = esci_pkg::ST_IDLE;
                end
            endcase
            // skip lets a held start restart the selected program
            if (in_s.motion_skip && in_s.prog_start) begin
                st_nxt.stat.restart_top = 1'b1;
            end
        end
        // step-done and fail-set are one-shot command bits
        st_nxt.ctrl[esci_pkg::CTRL_STEP_DONE]  = 1'b0;
        st_nxt.ctrl[esci_pkg::CTRL_DECEL_DONE] = 1'b0;
        st_nxt.ctrl[esci_pkg::CTRL_FAIL_SET]   = 1'b0;

        // wishbone: ack one cycle after strobe, dropped the next cycle
        st_nxt.ack = WB_CYC_I && WB_STB_I && !st_r.ack;
        wr = st_nxt.ack && WB_WE_I;
        if (wr && WB_ADR_I == esci_pkg::REG_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (WB_SEL_I[b]) begin
                    st_nxt.ctrl[b*8 +: 8] = WB_DAT_I[b*8 +: 8];
                end
            end
        end
        // a refusal raised in the same cycle wins over the software clear
        if (wr && WB_ADR_I == esci_pkg::REG_ERROR && WB_SEL_I[0]
            && in_s.motion_halt && !err_new) begin
            st_nxt.err = esci_pkg::ERR_NONE;
        end
        st_nxt.dat = 32'h0000_0000;
        if (st_nxt.ack && !WB_WE_I) begin
            rd_valid = 1'b1;
            case (WB_ADR_I)
                esci_pkg::REG_CTRL:   st_nxt.dat = st_r.ctrl;
                esci_pkg::REG_STATUS: st_nxt.dat = {18'h0, st_r.run, st_r.stat};
                esci_pkg::REG_ERROR:  st_nxt.dat = {16'h0, st_r.err};
                esci_pkg::REG_INPUTS: st_nxt.dat = {23'h0, lvl};
                default:              st_nxt.dat = 32'h0000_0000;
            endcase
        end
        if (!rd_valid) begin
            st_nxt.dat = 32'h0000_0000;
        end
    end

    // register all state
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_r      <= '0;
            st_r.run  <= esci_pkg::ST_IDLE;
            st_r.ctrl <= esci_pkg::CTRL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign WB_DAT_O = st_r.dat;
    assign WB_ACK_O = st_r.ack;
    assign STATUS   = st_r.stat;
endmodule

/* rtl/esci_pkg.sv */
// package: constants, register map and carrier types for the external stop control inputs
package esci_pkg;
    // clock and timing
    localparam int          CLK_MHZ            = 100;
    localparam int          TICK_US            = 1000;
    localparam int          TICK_CYC           = TICK_US * CLK_MHZ;
    localparam int          IHALT_MIN_MS       = 50;
    localparam int          FCLR_LEAD_MS       = 1;
    // error codes reported to software
    localparam logic [15:0] ERR_NONE           = 16'h0000;
    localparam logic [15:0] ERR_HALT_OPEN      = 16'h2008;
    localparam logic [15:0] ERR_NO_CONTINUE    = 16'h27a8;
    // register byte offsets
    localparam logic [3:0]  REG_CTRL           = 4'h0;
    localparam logic [3:0]  REG_STATUS         = 4'h4;
    localparam logic [3:0]  REG_ERROR          = 4'h8;
    localparam logic [3:0]  REG_INPUTS         = 4'hc;
    // control field positions
    localparam int          CTRL_STEP_DONE     = 0;
    localparam int          CTRL_DECEL_DONE    = 1;
    localparam int          CTRL_CONT_PERMIT   = 2;
    localparam int          CTRL_SKIP_REGION   = 3;
    localparam int          CTRL_MOTION_CMD    = 4;
    localparam int          CTRL_FAIL_SET      = 5;
    localparam int          CTRL_PEND_REQ      = 6;
    localparam logic [31:0] CTRL_RST           = 32'h0000_0000;
    // number of discrete inputs
    localparam int          N_IN               = 9;

    // input bit order
    typedef struct packed {
        logic motion_halt;
        logic step_halt;
        logic instant_halt;
        logic failure_clear;
        logic motion_skip;
        logic resume_halted;
        logic prog_start;
        logic prep_start;
        logic prep_bits;
    } esci_in_t;

    // program run states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_RUN   = 5'b00010,
        ST_DECEL = 5'b00100,
        ST_STEPH = 5'b01000,
        ST_INSTH = 5'b10000
    } esci_run_t;

    // outward status carrier
    typedef struct packed {
        logic motor_on;
        logic in_operation;
        logic ext_mode;
        logic failure;
        logic blocked;
        logic pendant_ok;
        logic skip_step;
        logic restart_top;
        logic resume;
    } esci_stat_t;
endpackage

/* rtl/esci_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module esci_sync #(
    parameter int N = 9
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // raw pins and filtered levels
    input  wire logic [N-1:0] raw,
    output logic      [N-1:0] level
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] lv;
    } esci_sync_t;

    esci_sync_t st_r;
    esci_sync_t st_nxt;

    // level moves only when stages two and three agree; stage one feeds stage two only
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < N; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lv[i] = st_r.s3[i];
            end
        end
    end

    // register all state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lv;
endmodule

/* test/esci_assertions.sv */
// checker: port-level assertions for the stop control block
`timescale 1ns/100ps
module esci_assertions #(
    parameter int HALT_MIN_CYC = 20
) (
    // clock and reset
    input wire logic                      CLK,
    input wire logic                      RSTN,
    // pins and bus
    input wire logic [esci_pkg::N_IN-1:0] IN_SHORTED,
    input wire logic                      WB_CYC_I,
    input wire logic                      WB_STB_I,
    input wire logic [31:0]               WB_DAT_O,
    input wire logic                      WB_ACK_O,
    // status outputs
    input wire esci_pkg::esci_stat_t      STATUS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // bus answer comes one cycle after the request and lasts one cycle
    ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("data without ack");
    // eight cycles covers the synchroniser and the status register
    halt_block_a: assert property (!IN_SHORTED[8] [*8] |-> STATUS.blocked)
        else $error("halt open, not blocked");
    halt_energize_a: assert property ($rose(STATUS.motor_on) |-> !STATUS.blocked)
        else $error("motor on while blocked");
    halt_start_a: assert property (!IN_SHORTED[8] [*8] |-> !$rose(STATUS.in_operation))
        else $error("start beat the halt");
    start_edge_a: assert property ((!IN_SHORTED[4] && $stable(IN_SHORTED[2])) [*8]
        |-> !$rose(STATUS.in_operation)) else $error("run without start edge");
    clear_mask_a: assert property (IN_SHORTED[5] [*8] |-> !$rose(STATUS.motor_on))
        else $error("motor on during clear");
    clear_fail_a: assert property ($fell(STATUS.failure) |-> IN_SHORTED[5])
        else $error("failure cleared without clear input");
    resume_ext_a: assert property (STATUS.resume |-> STATUS.ext_mode)
        else $error("resume outside external mode");
    motor_c: cover property ($rose(STATUS.motor_on));
    stop_c: cover property ($fell(STATUS.in_operation) && STATUS.ext_mode);
    clear_c: cover property ($fell(STATUS.failure));
endmodule

bind esci_top esci_assertions #(.HALT_MIN_CYC(HALT_MIN_CYC)) u_chk (.CLK(CLK), .RSTN(RSTN),
    .IN_SHORTED(IN_SHORTED), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .STATUS(STATUS));

/* test/esci_plc_model.sv */
// partner model: sequencer driving the discrete stop and recovery inputs
`timescale 1ns/100ps
module esci_plc_model #(
    parameter int LEAD_CYC = 4,
    parameter int HOLD_CYC = 30
) (
    // clock
    input  wire logic       clk,
    // levels asked for by the bench, failure lamp from the device
    input  wire logic [8:0] want,
    input  wire logic       failure,
    // pin levels, high means shorted
    output logic      [8:0] pins
);
    int         lead_n    = 0;
    int         hold_n    = 0;
    logic [8:0] nxt;
    // this sequencer keeps its own program reset output open, so start may stay shorted
    logic       reset_out = 1'b0;
    initial pins = 9'h000;
    // pins follow the wishes, bent to what a careful sequencer must obey
    always @(posedge clk) begin
        lead_n <= pins[5] ? lead_n + 1 : 0;
        hold_n <= pins[6] ? 0 : hold_n + 1;
        nxt = want;
        if (want[4] && reset_out) nxt[2] = 1'b0;
        if (want[5] && lead_n < LEAD_CYC && !pins[1]) nxt[1] = 1'b0;
        if (!pins[6] && hold_n < HOLD_CYC) nxt[6] = 1'b0;
        if (failure && pins[5]) nxt[5] = 1'b1;
        pins <= nxt;
    end
endmodule

/* test/test_esci_top.sv */
// bench: stop, recovery and bus scenarios for the stop control block
`timescale 1ns/100ps
module test_esci_top;
    logic                 CLK = 1'b0;
    logic                 RSTN = 1'b0;
    logic [8:0]           want = 9'h0c0;
    logic [8:0]           pins;
    logic                 req = 1'b0;
    logic                 we = 1'b0;
    logic [3:0]           adr = 4'h0;
    logic [31:0]          wdat = 32'h0;
    logic [31:0]          rdat;
    logic [31:0]          dat_o;
    logic                 ack;
    esci_pkg::esci_stat_t st;
    int                   fails = 0;
    int                   checks_done = 0;
    int                   skip_n = 0;
    int                   res_n = 0;
    int                   rt_n = 0;
    esci_top #(.HALT_MIN_CYC(20)) DUT (.CLK(CLK), .RSTN(RSTN), .IN_SHORTED(pins),
        .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .STATUS(st));
    esci_plc_model #(.LEAD_CYC(4), .HOLD_CYC(30)) plc (.clk(CLK), .want(want),
        .failure(st.failure), .pins(pins));
    // clock, and counters for the status pulses; restart_top stays high while skip and start are held
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (st.skip_step === 1'b1) skip_n++;
        if (st.resume === 1'b1) res_n++;
        if (st.restart_top === 1'b1) rt_n++;
    end
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // one classic cycle; entered just after an edge, released at the ack edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no assumed latency: only the watchdog ends a wait that never sees ack
        do begin
            @(posedge CLK);
        end while (ack !== 1'b1);
        rdat = dat_o;
        req <= 1'b0;
        we <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        cmp(what, exp, rdat);
    endtask
    // waits up to n cycles for a status bit, zero means it must hold now
    task automatic bit_is(input string what, input int b, input logic v, input int n);
        int k;
        k = 0;
        while (st[b] !== v && k < n) begin
            @(posedge CLK);
            k++;
        end
        cmp(what, {31'h0, v}, {31'h0, st[b]});
    endtask
    // ten cycles covers the model register and the four-edge synchroniser
    task automatic put(input int b, input logic v);
        want[b] <= v;
        idle(10);
    endtask
    task automatic restart();
        put(2, 1'b0);
        put(2, 1'b1);
    endtask
    task automatic t_blocked();
        want <= 9'h0c7;
        idle(12);
        bit_is("blocked", 4, 1'b1, 60);
        bit_is("no motor", 8, 1'b0, 0);
        bit_is("no run", 7, 1'b0, 0);
        rd("err", esci_pkg::REG_ERROR, {16'h0, esci_pkg::ERR_HALT_OPEN});
        wb(1'b1, esci_pkg::REG_ERROR, 32'h1);
        rd("err kept", esci_pkg::REG_ERROR, {16'h0, esci_pkg::ERR_HALT_OPEN});
        rd("unmapped", 4'h2, 32'h0);
        want <= 9'h1c1;
        idle(12);
        rd("inputs", esci_pkg::REG_INPUTS, 32'h1c1);
        put(1, 1'b1);
        bit_is("motor", 8, 1'b1, 60);
        bit_is("ext", 6, 1'b1, 0);
        put(1, 1'b0);
    endtask
    task automatic t_step();
        put(2, 1'b1);
        bit_is("run", 7, 1'b1, 60);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h1);
        bit_is("run kept", 7, 1'b1, 0);
        put(7, 1'b0);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h1);
        bit_is("step stop", 7, 1'b0, 60);
        bit_is("ext kept", 6, 1'b1, 0);
        bit_is("pendant", 3, 1'b1, 0);
        restart();
        bit_is("step run", 7, 1'b1, 60);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h1);
        bit_is("single", 7, 1'b0, 60);
        put(7, 1'b1);
        restart();
        wb(1'b1, esci_pkg::REG_CTRL, 32'h18);
        cmp("no restart", 32'h0, 32'(rt_n));
        put(4, 1'b1);
        cmp("skip", 32'h1, 32'(skip_n));
        cmp("restart", 32'h1, 32'(rt_n != 0));
        put(4, 1'b0);
    endtask
    task automatic t_instant();
        int r0;
        put(6, 1'b0);
        bit_is("inst stop", 7, 1'b0, 60);
        bit_is("mode kept", 6, 1'b1, 0);
        put(6, 1'b1);
        idle(30);
        put(3, 1'b1);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h0);
        // earlier step-stop restarts also pulse resume, so count from here
        r0 = res_n;
        restart();
        rd("refused", esci_pkg::REG_ERROR, {16'h0, esci_pkg::ERR_NO_CONTINUE});
        bit_is("not resumed", 7, 1'b0, 0);
        cmp("no resume", 32'h0, 32'(res_n - r0));
        wb(1'b1, esci_pkg::REG_CTRL, 32'h4);
        restart();
        bit_is("resumed", 7, 1'b1, 60);
        cmp("resume", 32'h1, 32'(res_n - r0));
        put(3, 1'b0);
    endtask
    task automatic t_halt_fail();
        put(8, 1'b0);
        bit_is("decel motor", 8, 1'b1, 0);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h2);
        bit_is("motor off", 8, 1'b0, 60);
        bit_is("internal", 6, 1'b0, 0);
        put(8, 1'b1);
        wb(1'b1, esci_pkg::REG_CTRL, 32'h20);
        bit_is("failure", 5, 1'b1, 60);
        put(5, 1'b1);
        put(1, 1'b1);
        bit_is("cleared", 5, 1'b0, 60);
        // second preparation edge with no failure left: only the clear input masks it
        put(1, 1'b0);
        put(1, 1'b1);
        bit_is("masked", 8, 1'b0, 0);
        bit_is("masked mode", 6, 1'b0, 0);
        put(5, 1'b0);
        put(1, 1'b0);
        put(1, 1'b1);
        bit_is("recovered", 8, 1'b1, 60);
    endtask
    // reset for four cycles, then the scenarios in order
    initial begin
        idle(4);
        RSTN <= 1'b1;
        t_blocked();
        t_step();
        t_instant();
        t_halt_fail();
        report_and_stop();
    end
    // watchdog, far beyond the few hundred cycles the scenarios take
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        report_and_stop();
    end
endmodule
